// ==== src/tcc_pkg.sv ====
// Constants, carriers and helpers for the timer capture/compare control block.
// Assumes a 16-bit byte address on an Avalon-MM slave with 32-bit data.
// How it works
// - Writing one to a channel overflow flag sets it, as a counter wrap does.
// - The primary pin valid edge comes from prescaler bits 5 and 4.
// - Reset clears each capture/compare control register to zero.
// - Control registers update only when byte lane 0 is enabled; writes on other lanes alone are ignored.
// - Control bit 2 makes the second register capture (1) or compare (0).
// - Control bit 0 makes the first register capture (1) or compare (0).
// - Control bit 1 picks the first register trigger: secondary pin or reversed primary pin.
// - Both-edge select with the reversed trigger detects no primary edge.
// - A secondary edge that does not capture raises the first register interrupt.
// - Operation-enable 00 stops and clears the channel; 01, 10, 11 pick the run mode.
// - The overflow flag clears on a zero write or when operation-enable is 00.
package tcc_pkg;

	// Register byte addresses
	localparam logic [15:0] OFS_CTRL_CH1   = 16'hffb8;
	localparam logic [15:0] OFS_CTRL_CH0   = 16'hffbc;
	localparam logic [15:0] OFS_MODE_CH0   = 16'hff00;
	localparam logic [15:0] OFS_MODE_CH1   = 16'hff04;
	localparam logic [15:0] OFS_PRE_CH0    = 16'hff08;
	localparam logic [15:0] OFS_PRE_CH1    = 16'hff0c;
	localparam logic [15:0] OFS_CNT_CH0    = 16'hff10;
	localparam logic [15:0] OFS_CNT_CH1    = 16'hff14;
	localparam logic [15:0] OFS_CC1_CH0    = 16'hff20;
	localparam logic [15:0] OFS_CC2_CH0    = 16'hff24;
	localparam logic [15:0] OFS_CC1_CH1    = 16'hff28;
	localparam logic [15:0] OFS_CC2_CH1    = 16'hff2c;
	localparam logic [15:0] OFS_IRQ_STAT   = 16'hff30;
	localparam logic [15:0] OFS_IRQ_MASK   = 16'hff34;

	// Field positions
	localparam int unsigned MODE_OVF_BIT   = 0;
	localparam int unsigned MODE_OPEN_LSB  = 2;
	localparam int unsigned PRE_ES_PRI_LSB = 4;
	localparam int unsigned PRE_ES_SEC_LSB = 6;

	// Reset values and counter maximum
	localparam logic [2:0]  CTRL_RST       = 3'h0;
	localparam logic [1:0]  OPEN_RST       = 2'h0;
	localparam logic [1:0]  ES_RST         = 2'h0;
	localparam logic [3:0]  IRQ_RST        = 4'h0;
	localparam logic [15:0] CNT_MAX        = 16'hffff;

	// Edge-select codes
	localparam logic [1:0]  ES_FALL        = 2'h0;
	localparam logic [1:0]  ES_RISE        = 2'h1;
	localparam logic [1:0]  ES_BOTH        = 2'h3;

	// Decoded operation-enable field
	typedef enum logic [3:0] {
		TCC_STOP      = 4'h1,
		TCC_FREE      = 4'h2,
		TCC_CLR_PIN   = 4'h4,
		TCC_CLR_MATCH = 4'h8
	} tcc_mode_t;

	// Capture/compare control fields
	typedef struct packed {
		logic second_mode;
		logic trig_sel;
		logic first_mode;
	} tcc_ctrl_t;

	// Channel configuration
	typedef struct packed {
		logic [1:0] op_en;
		logic [1:0] es_pri;
		logic [1:0] es_sec;
		tcc_ctrl_t  ctrl;
	} tcc_cfg_t;

	// Software write strobes into a channel
	typedef struct packed {
		logic        ovf;
		logic        cc1;
		logic        cc2;
		logic [15:0] data;
	} tcc_wr_t;

	// Channel state seen by the bus side
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] cc1;
		logic [15:0] cc2;
		logic        ovf;
		logic        evt1;
		logic        evt2;
	} tcc_stat_t;

	// Pin edge pulses
	typedef struct packed {
		logic rise;
		logic fall;
	} tcc_edge_t;

	// Operation-enable to run mode
	function automatic tcc_mode_t tcc_decode_mode(input logic [1:0] op_en);
		case (op_en)
			2'h1: tcc_decode_mode = TCC_FREE;
			2'h2: tcc_decode_mode = TCC_CLR_PIN;
			2'h3: tcc_decode_mode = TCC_CLR_MATCH;
			default: tcc_decode_mode = TCC_STOP;
		endcase
	endfunction

	// Valid edge test, optionally in reverse phase
	function automatic logic tcc_valid_edge(input logic [1:0] es, input tcc_edge_t e,
			input logic rev);
		case (es)
			ES_FALL: tcc_valid_edge = rev ? e.rise : e.fall;
			ES_RISE: tcc_valid_edge = rev ? e.fall : e.rise;
			ES_BOTH: tcc_valid_edge = rev ? 1'b0 : (e.rise | e.fall);
			default: tcc_valid_edge = 1'b0;
		endcase
	endfunction

endpackage

// ==== src/tcc_edge.sv ====
// Edge detector for one trigger pin.
// Assumes the pin is synchronous to the system clock.
module tcc_edge
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_sys_i,
	input  wire logic      rst_n_i,
	// Control and pin
	input  wire logic      clr_i,
	input  wire logic      pin_i,
	// Edge pulses
	output tcc_edge_t      edge_o
);
	import tcc_pkg::*;

	typedef struct packed {
		logic      prev;
		logic      armed;
		tcc_edge_t pulse;
	} tcc_edge_state_t;

	tcc_edge_state_t s_r;
	tcc_edge_state_t s_nxt;

	// Pulse on a change; after a clear the first sample only arms
	always_comb begin
		s_nxt            = s_r;
		s_nxt.prev       = pin_i;
		s_nxt.armed      = ~clr_i;
		s_nxt.pulse.rise = s_r.armed & ~clr_i & pin_i & ~s_r.prev;
		s_nxt.pulse.fall = s_r.armed & ~clr_i & ~pin_i & s_r.prev;
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign edge_o = s_r.pulse;

endmodule

// ==== src/tcc_chan.sv ====
// One timer channel: counter, overflow flag, two capture/compare registers.
// Assumes edge pulses from tcc_edge and write strobes from the bus side.
module tcc_chan
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_sys_i,
	input  wire logic      rst_n_i,
	// Configuration and writes
	input  tcc_cfg_t       cfg_i,
	input  tcc_wr_t        wr_i,
	// Pin edges
	input  tcc_edge_t      pri_i,
	input  tcc_edge_t      sec_i,
	// State
	output tcc_stat_t      stat_o
);
	import tcc_pkg::*;

	tcc_stat_t s_r;
	tcc_stat_t s_nxt;
	tcc_mode_t mode;
	logic      pri_ok;
	logic      pri_rev;
	logic      sec_ok;
	logic      cap1;
	logic      cap2;
	logic      ext1;
	logic      match1;
	logic      match2;
	logic      clr_cnt;

	// Trigger qualification
	always_comb begin
		mode    = tcc_decode_mode(cfg_i.op_en);
		pri_ok  = tcc_valid_edge(cfg_i.es_pri, pri_i, 1'b0);
		pri_rev = tcc_valid_edge(cfg_i.es_pri, pri_i, 1'b1);
		sec_ok  = tcc_valid_edge(cfg_i.es_sec, sec_i, 1'b0);
		cap1    = cfg_i.ctrl.first_mode & (cfg_i.ctrl.trig_sel ? pri_rev : sec_ok);
		cap2    = cfg_i.ctrl.second_mode & pri_ok;
		ext1    = sec_ok & ~(cfg_i.ctrl.first_mode & ~cfg_i.ctrl.trig_sel);
		match1  = ~cfg_i.ctrl.first_mode & (s_r.cnt == s_r.cc1);
		match2  = ~cfg_i.ctrl.second_mode & (s_r.cnt == s_r.cc2);
	end

	// Next channel state
	always_comb begin
		s_nxt      = s_r;
		s_nxt.evt1 = 1'b0;
		s_nxt.evt2 = 1'b0;
		clr_cnt    = 1'b0;
		if (wr_i.cc1) begin
			s_nxt.cc1 = wr_i.data;
		end
		if (wr_i.cc2) begin
			s_nxt.cc2 = wr_i.data;
		end
		if (wr_i.ovf) begin
			s_nxt.ovf = wr_i.data[MODE_OVF_BIT];
		end
		case (mode)
			TCC_STOP: clr_cnt = 1'b1;
			TCC_FREE: clr_cnt = 1'b0;
			TCC_CLR_PIN: clr_cnt = pri_ok;
			// match clear relies on compare mode
			TCC_CLR_MATCH: clr_cnt = match1;
			default: clr_cnt = 1'b1;
		endcase
		if (mode == TCC_STOP) begin
			// stopped channel held clear; the stop seen here is one cycle
			// old, so a write of one that also starts the channel still lands
			s_nxt.cnt = '0;
			s_nxt.ovf = wr_i.ovf & wr_i.data[MODE_OVF_BIT];
		end else begin
			s_nxt.cnt  = clr_cnt ? '0 : s_r.cnt + 16'h1;
			// Wrap sets the flag over any clear
			if (!clr_cnt && s_r.cnt == CNT_MAX) begin
				s_nxt.ovf = 1'b1;
			end
			if (cap1) begin
				s_nxt.cc1 = s_r.cnt;
			end
			if (cap2) begin
				s_nxt.cc2 = s_r.cnt;
			end
			s_nxt.evt1 = cap1 | match1 | ext1;
			s_nxt.evt2 = cap2 | match2;
		end
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign stat_o = s_r;

endmodule

// ==== src/tcc_top.sv ====
// Timer capture/compare control: two channels behind an Avalon-MM slave.
// Assumes trigger pins synchronous to clk_sys_i; one waitrequest cycle per access.
module tcc_top
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// Avalon-MM slave
	input  wire logic [15:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Trigger pins
	input  wire logic        primary_trigger_pin_ch0_i,
	input  wire logic        secondary_trigger_pin_ch0_i,
	input  wire logic        primary_trigger_pin_ch1_i,
	input  wire logic        secondary_trigger_pin_ch1_i,
	// Interrupts
	output logic             first_reg_irq_ch0_o,
	output logic             first_reg_irq_ch1_o,
	output logic             irq_o
);
	import tcc_pkg::*;

	typedef struct packed {
		tcc_ctrl_t   ctrl0;
		tcc_ctrl_t   ctrl1;
		logic [1:0]  op_en0;
		logic [1:0]  op_en1;
		logic [3:0]  es0;
		logic [3:0]  es1;
		logic [3:0]  irq_st;
		logic [3:0]  irq_mask;
		logic        ack;
		logic [31:0] rdata;
	} tcc_top_state_t;

	tcc_top_state_t s_r;
	tcc_top_state_t s_nxt;
	tcc_cfg_t       cfg0;
	tcc_cfg_t       cfg1;
	tcc_wr_t        wr0;
	tcc_wr_t        wr1;
	tcc_stat_t      st0;
	tcc_stat_t      st1;
	tcc_edge_t      pri0;
	tcc_edge_t      sec0;
	tcc_edge_t      pri1;
	tcc_edge_t      sec1;
	logic           req;
	logic           wr_go;
	logic           lo_be;
	logic [3:0]     evts;

	// Merge written byte lanes into a 16-bit value
	function automatic logic [15:0] tcc_merge16(input logic [15:0] cur,
			input logic [31:0] wd, input logic [3:0] be);
		tcc_merge16 = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
	endfunction

	// Register read multiplexer
	function automatic logic [31:0] tcc_read(input tcc_top_state_t s,
			input logic [15:0] a, input tcc_stat_t c0, input tcc_stat_t c1);
		tcc_read = 32'h0;
		case (a)
			OFS_CTRL_CH0: tcc_read = {29'h0, s.ctrl0};
			OFS_CTRL_CH1: tcc_read = {29'h0, s.ctrl1};
			OFS_MODE_CH0: tcc_read = {28'h0, s.op_en0, 1'b0, c0.ovf};
			OFS_MODE_CH1: tcc_read = {28'h0, s.op_en1, 1'b0, c1.ovf};
			OFS_PRE_CH0: tcc_read = {24'h0, s.es0, 4'h0};
			OFS_PRE_CH1: tcc_read = {24'h0, s.es1, 4'h0};
			OFS_CNT_CH0: tcc_read = {16'h0, c0.cnt};
			OFS_CNT_CH1: tcc_read = {16'h0, c1.cnt};
			OFS_CC1_CH0: tcc_read = {16'h0, c0.cc1};
			OFS_CC2_CH0: tcc_read = {16'h0, c0.cc2};
			OFS_CC1_CH1: tcc_read = {16'h0, c1.cc1};
			OFS_CC2_CH1: tcc_read = {16'h0, c1.cc2};
			OFS_IRQ_STAT: tcc_read = {28'h0, s.irq_st};
			OFS_IRQ_MASK: tcc_read = {28'h0, s.irq_mask};
			default: tcc_read = 32'h0;
		endcase
	endfunction

	// Bus handshake: one wait cycle, then the transfer edge
	always_comb begin
		req               = avs_read_i | avs_write_i;
		avs_waitrequest_o = req & ~s_r.ack;
		wr_go             = avs_write_i & s_r.ack;
		lo_be             = wr_go & avs_byteenable_i[0];
	end

	// Channel configuration from registers
	always_comb begin
		cfg0.op_en  = s_r.op_en0;
		cfg0.es_pri = s_r.es0[1:0];
		cfg0.es_sec = s_r.es0[3:2];
		cfg0.ctrl   = s_r.ctrl0;
		cfg1.op_en  = s_r.op_en1;
		cfg1.es_pri = s_r.es1[1:0];
		cfg1.es_sec = s_r.es1[3:2];
		cfg1.ctrl   = s_r.ctrl1;
	end

	// Channel write strobes
	always_comb begin
		wr0.ovf  = lo_be & (avs_address_i == OFS_MODE_CH0);
		wr0.cc1  = wr_go & (avs_address_i == OFS_CC1_CH0);
		wr0.cc2  = wr_go & (avs_address_i == OFS_CC2_CH0);
		wr0.data = wr0.ovf ? avs_writedata_i[15:0] :
			tcc_merge16(wr0.cc1 ? st0.cc1 : st0.cc2, avs_writedata_i, avs_byteenable_i);
		wr1.ovf  = lo_be & (avs_address_i == OFS_MODE_CH1);
		wr1.cc1  = wr_go & (avs_address_i == OFS_CC1_CH1);
		wr1.cc2  = wr_go & (avs_address_i == OFS_CC2_CH1);
		wr1.data = wr1.ovf ? avs_writedata_i[15:0] :
			tcc_merge16(wr1.cc1 ? st1.cc1 : st1.cc2, avs_writedata_i, avs_byteenable_i);
	end

	// Next register state
	always_comb begin
		s_nxt     = s_r;
		s_nxt.ack = req & ~s_r.ack;
		evts      = {st1.evt2, st1.evt1, st0.evt2, st0.evt1};
		if (avs_read_i && !s_r.ack) begin
			s_nxt.rdata = tcc_read(s_r, avs_address_i, st0, st1);
		end
		if (lo_be) begin
			case (avs_address_i)
				OFS_CTRL_CH0: s_nxt.ctrl0 = avs_writedata_i[2:0];
				OFS_CTRL_CH1: s_nxt.ctrl1 = avs_writedata_i[2:0];
				OFS_MODE_CH0: s_nxt.op_en0 = avs_writedata_i[MODE_OPEN_LSB +: 2];
				OFS_MODE_CH1: s_nxt.op_en1 = avs_writedata_i[MODE_OPEN_LSB +: 2];
				OFS_PRE_CH0: s_nxt.es0 = avs_writedata_i[PRE_ES_PRI_LSB +: 4];
				OFS_PRE_CH1: s_nxt.es1 = avs_writedata_i[PRE_ES_PRI_LSB +: 4];
				OFS_IRQ_STAT: s_nxt.irq_st = s_r.irq_st & ~avs_writedata_i[3:0];
				OFS_IRQ_MASK: s_nxt.irq_mask = avs_writedata_i[3:0];
				default: s_nxt.irq_mask = s_r.irq_mask;
			endcase
		end
		// Events set status over a same-cycle clear
		s_nxt.irq_st = s_nxt.irq_st | evts;
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r.ctrl0    <= CTRL_RST;
			s_r.ctrl1    <= CTRL_RST;
			s_r.op_en0   <= OPEN_RST;
			s_r.op_en1   <= OPEN_RST;
			s_r.es0      <= {ES_RST, ES_RST};
			s_r.es1      <= {ES_RST, ES_RST};
			s_r.irq_st   <= IRQ_RST;
			s_r.irq_mask <= IRQ_RST;
			s_r.ack      <= 1'b0;
			s_r.rdata    <= 32'h0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Pin edge detectors, cleared while the channel is stopped
	tcc_edge u_pri0 (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clr_i     (s_r.op_en0 == OPEN_RST),
		.pin_i     (primary_trigger_pin_ch0_i),
		.edge_o    (pri0)
	);
	tcc_edge u_sec0 (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clr_i     (s_r.op_en0 == OPEN_RST),
		.pin_i     (secondary_trigger_pin_ch0_i),
		.edge_o    (sec0)
	);
	tcc_edge u_pri1 (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clr_i     (s_r.op_en1 == OPEN_RST),
		.pin_i     (primary_trigger_pin_ch1_i),
		.edge_o    (pri1)
	);
	tcc_edge u_sec1 (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clr_i     (s_r.op_en1 == OPEN_RST),
		.pin_i     (secondary_trigger_pin_ch1_i),
		.edge_o    (sec1)
	);

	// Channels
	tcc_chan u_ch0 (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.cfg_i     (cfg0),
		.wr_i      (wr0),
		.pri_i     (pri0),
		.sec_i     (sec0),
		.stat_o    (st0)
	);
	tcc_chan u_ch1 (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.cfg_i     (cfg1),
		.wr_i      (wr1),
		.pri_i     (pri1),
		.sec_i     (sec1),
		.stat_o    (st1)
	);

	// Outputs
	assign avs_readdata_o      = s_r.rdata;
	assign first_reg_irq_ch0_o = st0.evt1;
	assign first_reg_irq_ch1_o = st1.evt1;
	assign irq_o               = |(s_r.irq_st & s_r.irq_mask);

endmodule

// ==== bench/tcc_top_monitor.sv ====
// Port-level checks for the timer capture/compare control block.
// Assumes it is bound into tcc_top and sees only that module's ports.
module tcc_top_monitor
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	// Avalon-MM slave
	input wire logic [15:0] avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// Pins and interrupts
	input wire logic        primary_trigger_pin_ch0_i,
	input wire logic        secondary_trigger_pin_ch0_i,
	input wire logic        primary_trigger_pin_ch1_i,
	input wire logic        secondary_trigger_pin_ch1_i,
	input wire logic        first_reg_irq_ch0_o,
	input wire logic        first_reg_irq_ch1_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] ctrl0_r;
	logic [2:0] ctrl1_r;
	logic [1:0] op0_r;
	logic [1:0] op1_r;
	logic       ovf1_r;
	logic       wr_ok;
	logic       op0_z;
	logic       op1_z;
	logic [1:0] pins0;
	logic [1:0] pins1;

	// Accepted byte-lane writes and decoded flags
	assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	assign op0_z = (op0_r == 2'h0);
	assign op1_z = (op1_r == 2'h0);
	assign pins0 = {secondary_trigger_pin_ch0_i, primary_trigger_pin_ch0_i};
	assign pins1 = {secondary_trigger_pin_ch1_i, primary_trigger_pin_ch1_i};

	// Shadow of the software-written fields
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl0_r <= 3'h0;
			ctrl1_r <= 3'h0;
			op0_r   <= 2'h0;
			op1_r   <= 2'h0;
			ovf1_r  <= 1'b0;
		end else if (wr_ok) begin
			if (avs_address_i == OFS_CTRL_CH0)
				ctrl0_r <= avs_writedata_i[2:0];
			if (avs_address_i == OFS_CTRL_CH1)
				ctrl1_r <= avs_writedata_i[2:0];
			if (avs_address_i == OFS_MODE_CH0)
				op0_r <= avs_writedata_i[3:2];
			if (avs_address_i == OFS_MODE_CH1) begin
				op1_r  <= avs_writedata_i[3:2];
				ovf1_r <= avs_writedata_i[0] && (avs_writedata_i[3:2] != 2'h0);
			end
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// Completed read of one address
	sequence rd_done(logic [15:0] a);
		avs_read_i && !avs_waitrequest_o && (avs_address_i == a);
	endsequence

	ctrl0_read_a: assert property (
		rd_done(OFS_CTRL_CH0) |-> avs_readdata_o[7:0] == {5'h00, ctrl0_r})
		else $error("control ch0 readback differs from last write");
	ctrl1_read_a: assert property (
		rd_done(OFS_CTRL_CH1) |-> avs_readdata_o[7:0] == {5'h00, ctrl1_r})
		else $error("control ch1 readback differs from last write");
	cnt_stopped_a: assert property (
		rd_done(OFS_CNT_CH0) ##0 op0_z |-> avs_readdata_o == 32'h0)
		else $error("stopped counter ch0 not zero");
	irq_stop0_a: assert property (
		op0_z && $past(op0_z) && $past(op0_z, 2) |-> !first_reg_irq_ch0_o)
		else $error("ch0 event while stopped");
	irq_stop1_a: assert property (
		op1_z && $past(op1_z) && $past(op1_z, 2) |-> !first_reg_irq_ch1_o)
		else $error("ch1 event while stopped");
	ovf_set_a: assert property (
		rd_done(OFS_MODE_CH1) ##0 ovf1_r |-> avs_readdata_o[0])
		else $error("overflow flag not set by write of one");
	ovf_clear_a: assert property (
		rd_done(OFS_MODE_CH1) ##0 op1_z |-> !avs_readdata_o[0])
		else $error("overflow flag not cleared while stopped");
	irq_cause0_a: assert property (
		first_reg_irq_ch0_o && ctrl0_r[0] |-> $past(pins0, 2) != $past(pins0, 4))
		else $error("ch0 capture event without a pin edge");
	irq_cause1_a: assert property (
		first_reg_irq_ch1_o && ctrl1_r[0] |-> $past(pins1, 2) != $past(pins1, 4))
		else $error("ch1 capture event without a pin edge");
endmodule

bind tcc_top tcc_top_monitor tcc_top_monitor_inst (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.primary_trigger_pin_ch0_i(primary_trigger_pin_ch0_i),
	.secondary_trigger_pin_ch0_i(secondary_trigger_pin_ch0_i),
	.primary_trigger_pin_ch1_i(primary_trigger_pin_ch1_i),
	.secondary_trigger_pin_ch1_i(secondary_trigger_pin_ch1_i),
	.first_reg_irq_ch0_o(first_reg_irq_ch0_o), .first_reg_irq_ch1_o(first_reg_irq_ch1_o),
	.irq_o(irq_o)
);

// ==== bench/tcc_pin_src.sv ====
// Behavioural source driving the four trigger pins.
// Assumes one-cycle toggle requests spaced wider than the hold time.
module tcc_pin_src #(
	parameter int HOLD = 3
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// Toggle requests, one bit per pin
	input  wire logic [3:0] toggle_i,
	// Pin levels: pri0, sec0, pri1, sec1
	output logic [3:0]      pin_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int hold_q;

	// Pin levels; a new edge waits out the hold time
	// minimum pulse width
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o  <= 4'h0;
			hold_q <= 0;
		end else if (hold_q != 0) begin
			hold_q <= hold_q - 1;
		end else if (toggle_i != 4'h0) begin
			pin_o  <= pin_o ^ toggle_i;
			hold_q <= HOLD;
		end
	end
endmodule

// ==== bench/tcc_top_tb.sv ====
// Self-checking bench for the timer capture/compare control block.
// Assumes tcc_pin_src drives the trigger pins and the monitor is bound.
module tcc_top_tb
	import tcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys_i        = 1'b0;
	logic        rst_n_i          = 1'b0;
	logic [15:0] avs_address_i    = 16'h0000;
	logic        avs_read_i       = 1'b0;
	logic        avs_write_i      = 1'b0;
	logic [31:0] avs_writedata_i  = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'h0;
	logic [3:0]  toggle_r         = 4'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [3:0]  pin_w;
	logic        irq0_w;
	logic        irq1_w;
	logic        irq_o;
	int          miscompares      = 0;
	int          cmp_count        = 0;
	int          cyc              = 0;
	int          irq_pulses       = 0;
	int unsigned rng              = 32'h4cd5;
	// Scenario table: channel, control, prescaler, op-enable, secondary pin
	int          cs_ch[8]         = '{0, 0, 0, 0, 0, 0, 1, 1};
	int          cs_ctl[8]        = '{3, 3, 0, 1, 4, 4, 4, 0};
	int          cs_pre[8]        = '{8'h10, 8'h30, 8'h40, 8'h40, 8'h10, 8'h10, 8'h00, 8'hc0};
	// match-clear mode only with the first register in compare mode
	int          cs_op[8]         = '{1, 1, 3, 1, 1, 0, 1, 2};
	int          cs_sec[8]        = '{0, 0, 1, 1, 0, 0, 0, 1};

	tcc_top tcc_top_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .primary_trigger_pin_ch0_i(pin_w[0]),
		.secondary_trigger_pin_ch0_i(pin_w[1]), .primary_trigger_pin_ch1_i(pin_w[2]),
		.secondary_trigger_pin_ch1_i(pin_w[3]), .first_reg_irq_ch0_o(irq0_w),
		.first_reg_irq_ch1_o(irq1_w), .irq_o(irq_o));
	tcc_pin_src #(.HOLD(3)) tcc_pin_src_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .toggle_i(toggle_r), .pin_o(pin_w));

	// 20 MHz clock
	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	// Hang guard
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			$display("MISMATCH t=%0t run too long", $time);
			report_and_stop();
		end
	end

	// First register event pulses, both channels
	always @(posedge clk_sys_i) begin
		irq_pulses <= irq_pulses + int'(irq0_w) + int'(irq1_w);
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_range(input logic [31:0] got, input int lo, input int hi);
		cmp_count++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			miscompares++;
			$display("MISMATCH t=%0t capture %h outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	function automatic int unsigned xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Expected status bits from one pin edge
	function automatic int model_evt(int ch, int ctl, int pre, int op, int sec, int rise);
		int es;
		int v;
		int vr;
		int e;
		es = (pre >> (sec ? 6 : 4)) & 3;
		v  = (es == 3) || (es == 1 && rise) || (es == 0 && !rise);
		vr = (es == 1 && !rise) || (es == 0 && rise);
		if (op == 0)
			e = 0;
		else if (sec)
			e = v;
		else
			e = int'((ctl & 3) == 3 && vr) | (int'((ctl & 4) != 0 && v) << 1);
		return e << (2 * ch);
	endfunction

	// Avalon-MM transfer held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		@(posedge clk_sys_i);
		avs_address_i    <= a;
		avs_write_i      <= wr;
		avs_read_i       <= !wr;
		avs_writedata_i  <= d;
		avs_byteenable_i <= be;
		do
			@(posedge clk_sys_i);
		while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, 4'hf, q);
	endtask

	// One pin toggle, then time for the event to settle
	task automatic toggle(input int k);
		@(posedge clk_sys_i);
		toggle_r <= 4'h1 << k;
		@(posedge clk_sys_i);
		toggle_r <= 4'h0;
		repeat (8) @(posedge clk_sys_i);
	endtask

	// Main sequence
	initial begin
		logic [31:0] q;
		int          c;
		int          m_stat;
		int          lo;
		int          hi;
		int unsigned r;
		int          pb;
		int          pe;
		int          e;
		rng = 19669;
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(OFS_CTRL_CH0, q);
		chk(q, 32'h0);
		bus(1'b1, OFS_CTRL_CH1, 32'hff, 4'h2, q);
		rd(OFS_CTRL_CH1, q);
		chk(q, 32'h0);
		rd(16'hff40, q);
		chk(q, 32'h0);
		for (int i = 0; i < 8; i++) begin
			c = cs_ch[i];
			// stop the channel before its control changes
			wr(16'(OFS_MODE_CH0 + 4 * c), 32'h0);
			wr(c ? OFS_CTRL_CH1 : OFS_CTRL_CH0, 32'hf8 | cs_ctl[i]);
			rd(c ? OFS_CTRL_CH1 : OFS_CTRL_CH0, q);
			chk(q, cs_ctl[i]);
			wr(16'(OFS_PRE_CH0 + 4 * c), cs_pre[i]);
			wr(16'(OFS_CC1_CH0 + 8 * c), 32'hffff);
			wr(16'(OFS_CC2_CH0 + 8 * c), 32'hffff);
			wr(16'(OFS_MODE_CH0 + 4 * c), cs_op[i] << 2);
			wr(OFS_IRQ_STAT, 32'hf);
			m_stat = 0;
			pb     = irq_pulses;
			pe     = 0;
			rd(16'(OFS_CNT_CH0 + 4 * c), q);
			lo = int'(q);
			for (int rise = 1; rise >= 0; rise--) begin
				toggle(2 * c + cs_sec[i]);
				e       = model_evt(c, cs_ctl[i], cs_pre[i], cs_op[i], cs_sec[i], rise);
				m_stat |= e;
				pe     += (e >> (2 * c)) & 1;
				rd(OFS_IRQ_STAT, q);
				chk(q, m_stat);
			end
			chk(irq_pulses - pb, pe);
			rd(16'(OFS_CNT_CH0 + 4 * c), q);
			hi = int'(q);
			rd(16'(OFS_CC1_CH0 + 8 * c), q);
			if ((cs_ctl[i] & 1) && m_stat[2 * c])
				chk_range(q, lo, hi);
			rd(16'(OFS_CC2_CH0 + 8 * c), q);
			if ((cs_ctl[i] & 4) && m_stat[2 * c + 1])
				chk_range(q, lo, hi);
		end
		// Interrupt masked, unmasked, then cleared
		wr(OFS_IRQ_MASK, 32'hb);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h4);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h1);
		wr(OFS_IRQ_STAT, 32'h4);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h0);
		// Overflow flag set and cleared by software, random order
		for (int i = 0; i < 8; i++) begin
			r = xs();
			wr(OFS_MODE_CH1, {28'h0, 1'b0, r[1], 1'b0, r[0]});
			rd(OFS_MODE_CH1, q);
			chk({31'h0, q[0]}, {31'h0, r[1] & r[0]});
		end
		report_and_stop();
	end
endmodule
